// ===== src/ocfs_top.sv
module ocfs_top
	import ocfs_pkg::*;
(
	input wire logic pclk, // Clock, 40 MHz
	input wire logic presetn, // Power-on reset, active low
	input wire logic clk_en, // Clock enable, freezes state when low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic ss_done, // Soft-start complete, same clock
	input wire logic [1:0] pwm_core, // Core PWM requests, internal channels
	input wire logic pwm_aux, // Auxiliary PWM request
	input wire logic [3:0] pwm_ext, // External phase PWM requests
	input wire logic [3:0] ext_active, // External phases in use
	input wire logic cmp_nom, // Core average above nominal level
	input wire logic cmp_raised, // Core average above raised soft-start level
	input wire logic cmp_high, // Core average above high level
	input wire logic cmp_psm, // Core average above power-saving trip
	input wire logic cmp_cap, // Timing capacitor above trip voltage
	input wire logic cmp_aux, // Auxiliary current above trip
	input wire logic [1:0] channel_current_limit, // Per-channel over limit
	output logic [1:0] upper_gate_drive, // Core upper gates
	output logic [1:0] lower_gate_drive, // Core lower gates
	output logic aux_upper_gate, // Auxiliary upper gate
	output logic aux_lower_gate, // Auxiliary lower gate
	output logic [3:0] ext_pwm_o, // External PWM level (c..f)
	output logic [3:0] ext_pwm_oe, // External PWM drive enable
	output logic power_good_o, // Open-drain power-good level (always 0)
	output logic power_good_oe, // Power-good pulls low while high
	output logic overcurrent_timer_source, // Charge timing capacitor
	output logic overcurrent_timer_ground, // Ground timing pin
	output logic ss_start, // Begin a soft-start attempt
	output logic power_saving_request_bit // Power-saving request flag
);
	// Sync lane map
	localparam int unsigned L_NOM = 0;
	localparam int unsigned L_RAISED = 1;
	localparam int unsigned L_HIGH = 2;
	localparam int unsigned L_PSM = 3;
	localparam int unsigned L_CAP = 4;
	localparam int unsigned L_AUX = 5;
	localparam int unsigned L_LIM = 6;

	typedef struct packed {
		ocfs_state_type core_st;
		logic aux_down;
		logic [2:0] core_tries;
		logic [2:0] aux_tries;
		logic [1:0] ctrl;
		logic psm_bit;
		logic [1:0] blk;
		logic [1:0] ug;
		logic [1:0] lg;
		logic aug;
		logic alg;
		logic [3:0] xo;
		logic [3:0] xoe;
		logic pg_oe;
		logic tsrc;
		logic tgnd;
		logic ss_go;
		logic tstart;
		logic [31:0] rdata;
		logic rdy;
		logic err;
	} ocfs_st_type;

	ocfs_st_type st_q, st_d;
	ocfs_cmp_if cmp ();
	logic wait_done;

	// Lanes 6 and 7 unused: channel limits take their own filtered path below
	assign cmp.raw = {2'h0, cmp_aux, cmp_cap, cmp_psm, cmp_high, cmp_raised, cmp_nom};

	ocfs_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(clk_en),
		.cmp(cmp.src)
	);

	// Channel limits use their own filtered path, kept in registers outside the state struct
	logic [1:0] lim_s1_q, lim_s2_q, lim_s3_q, lim_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim_s1_q <= '0;
			lim_s2_q <= '0;
			lim_s3_q <= '0;
			lim_q <= '0;
		end else if (clk_en) begin
			lim_s1_q <= channel_current_limit;
			lim_s2_q <= lim_s1_q;
			lim_s3_q <= lim_s2_q;
			for (int i = 0; i < NCH; i++) begin
				if (lim_s2_q[i] == lim_s3_q[i]) begin
					lim_q[i] <= lim_s3_q[i];
				end
			end
		end
	end

	ocfs_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.ce(clk_en),
		.start(st_q.tstart),
		.done(wait_done)
	);

	function automatic logic [31:0] rd_mux(input logic [7:0] a, input ocfs_st_type s);
		rd_mux = SLV_ERR_DATA;
		case (a)
			ADDR_CTRL: rd_mux = {29'h0, s.psm_bit, s.ctrl};
			ADDR_STATUS: rd_mux = {24'h0, s.pg_oe, s.aux_down, 3'h0, s.core_st};
			ADDR_COUNT: rd_mux = {26'h0, s.aux_tries, s.core_tries};
			default: rd_mux = SLV_ERR_DATA;
		endcase
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_COUNT);
	endfunction

	logic [7:0] cs;
	logic en, psm, core_trip, aux_trip, throttle;

	always_comb begin
		st_d = st_q;
		cs = cmp.sync;
		en = st_q.ctrl[CTRL_EN_BIT];
		psm = st_q.ctrl[CTRL_PSM_BIT];
		core_trip = 1'b0;
		aux_trip = 1'b0;
		throttle = 1'b0;
		if (clk_en) begin
			st_d.tstart = 1'b0;
			st_d.ss_go = 1'b0;
			// APB slave: zero-wait, answer in the access cycle
			st_d.rdy = 1'b0;
			st_d.err = 1'b0;
			if (psel && !penable) begin
				st_d.rdy = 1'b1;
				st_d.err = !addr_ok(paddr);
				st_d.rdata = pwrite ? 32'h0 : rd_mux(paddr, st_q);
			end
			if (psel && penable && st_q.rdy && pwrite && paddr == ADDR_CTRL) begin
				st_d.ctrl = pwdata[1:0];
			end
			// Core trip decision
			if (st_q.core_st == OCFS_SOFTSTART) begin
				core_trip = cs[L_RAISED];
			end else if (st_q.core_st == OCFS_RUN) begin
				if (psm) begin
					core_trip = cs[L_PSM];
				end else begin
					throttle = cs[L_NOM];
					core_trip = cs[L_HIGH] || (cs[L_NOM] && cs[L_CAP]);
				end
			end
			st_d.tsrc = throttle;
			st_d.tgnd = !throttle;
			aux_trip = cs[L_AUX] && !st_q.aux_down &&
				(st_q.core_st == OCFS_SOFTSTART || st_q.core_st == OCFS_RUN);
			case (st_q.core_st)
				OCFS_OFF: begin
					if (en) begin
						st_d.core_st = OCFS_SOFTSTART;
						st_d.ss_go = 1'b1;
					end
				end
				OCFS_SOFTSTART, OCFS_RUN: begin
					if (core_trip) begin
						if (psm) begin
							st_d.psm_bit = 1'b1;
							st_d.ctrl[CTRL_PSM_BIT] = 1'b0;
						end
						if (st_q.core_tries == MAX_ATTEMPTS - 3'h1) begin
							st_d.core_st = OCFS_LATCHED;
						end else begin
							st_d.core_tries = st_q.core_tries + 3'h1;
							st_d.core_st = OCFS_SHUTDOWN;
							st_d.tstart = 1'b1;
						end
					end else if (aux_trip) begin
						if (st_q.aux_tries == MAX_ATTEMPTS - 3'h1) begin
							st_d.core_st = OCFS_LATCHED;
						end else begin
							st_d.aux_tries = st_q.aux_tries + 3'h1;
							st_d.aux_down = 1'b1;
							st_d.tstart = 1'b1;
						end
					end else if (st_q.core_st == OCFS_SOFTSTART && ss_done) begin
						st_d.core_st = OCFS_RUN;
						st_d.core_tries = 3'h0;
						st_d.aux_tries = 3'h0;
					end
					if (st_q.aux_down && wait_done && !core_trip) begin
						st_d.aux_down = 1'b0;
					end
				end
				OCFS_SHUTDOWN: begin
					st_d.aux_down = 1'b0;
					if (wait_done) begin
						if (en) begin
							st_d.core_st = OCFS_SOFTSTART;
							st_d.ss_go = 1'b1;
						end else begin
							st_d.core_st = OCFS_OFF;
						end
					end
				end
				OCFS_LATCHED: begin
					st_d.core_st = OCFS_LATCHED;
				end
				default: begin
					st_d.core_st = OCFS_OFF;
				end
			endcase
			// Gate drive outputs
			for (int i = 0; i < NCH; i++) begin
				if (lim_q[i]) begin
					st_d.blk[i] = 1'b1;
				end else begin
					st_d.blk[i] = 1'b0;
				end
			end
			if (st_d.core_st == OCFS_SOFTSTART || st_d.core_st == OCFS_RUN) begin
				for (int i = 0; i < NCH; i++) begin
					st_d.ug[i] = pwm_core[i] && !st_d.blk[i];
					st_d.lg[i] = !pwm_core[i] || st_d.blk[i];
				end
				st_d.xo = pwm_ext;
				st_d.xoe = ext_active;
				st_d.aug = !st_d.aux_down && pwm_aux;
				st_d.alg = !st_d.aux_down && !pwm_aux;
				st_d.pg_oe = !(st_d.core_st == OCFS_RUN && !st_d.aux_down);
			end else begin
				st_d.ug = '0;
				st_d.lg = '0;
				st_d.xo = '0;
				st_d.xoe = '0;
				st_d.aug = 1'b0;
				st_d.alg = 1'b0;
				st_d.pg_oe = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '{core_st: OCFS_OFF, ctrl: CTRL_RESET, pg_oe: 1'b1, tgnd: 1'b1,
				default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata = st_q.rdata;
	assign pready = st_q.rdy;
	assign pslverr = st_q.err;
	assign upper_gate_drive = st_q.ug;
	assign lower_gate_drive = st_q.lg;
	assign aux_upper_gate = st_q.aug;
	assign aux_lower_gate = st_q.alg;
	assign ext_pwm_o = st_q.xo;
	assign ext_pwm_oe = st_q.xoe;
	assign power_good_o = 1'b0;
	assign power_good_oe = st_q.pg_oe;
	assign overcurrent_timer_source = st_q.tsrc;
	assign overcurrent_timer_ground = st_q.tgnd;
	assign ss_start = st_q.ss_go;
	assign power_saving_request_bit = st_q.psm_bit;
endmodule // ocfs_top

// ===== src/ocfs_pkg.sv
package ocfs_pkg;

	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned WAIT_MS = 12;
	localparam int unsigned WAIT_CYC_INT = (CLK_HZ / 1000) * WAIT_MS;
	localparam logic [19:0] WAIT_CYC = WAIT_CYC_INT[19:0];
	localparam logic [2:0] MAX_ATTEMPTS = 3'h7;
	localparam int unsigned NCH = 2;
	localparam int unsigned NEXT = 4;

	// APB register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_COUNT = 8'h08;

	// Control register fields
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_PSM_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [31:0] SLV_ERR_DATA = 32'h0000_0000;

	typedef enum logic [2:0] {
		OCFS_OFF,
		OCFS_SOFTSTART,
		OCFS_RUN,
		OCFS_SHUTDOWN,
		OCFS_LATCHED
	} ocfs_state_type;

endpackage : ocfs_pkg

// ===== src/ocfs_cmp_if.sv
interface ocfs_cmp_if;
	import ocfs_pkg::*;
	logic [7:0] raw;
	logic [7:0] sync;
	modport src (input raw, output sync);
	modport dst (input sync);
endinterface : ocfs_cmp_if

// ===== src/ocfs_sync.sv
module ocfs_sync
	import ocfs_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic ce, // Clock enable
	ocfs_cmp_if.src cmp // Raw in, filtered out
);
	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
		logic [7:0] o;
	} ocfs_sync_st_type;

	ocfs_sync_st_type st_q, st_d;

	// Change accepted only when second and third stages agree
	always_comb begin
		st_d = st_q;
		if (ce) begin
			st_d.s1 = cmp.raw;
			st_d.s2 = st_q.s1;
			st_d.s3 = st_q.s2;
			for (int i = 0; i < 8; i++) begin
				if (st_q.s2[i] == st_q.s3[i]) begin
					st_d.o[i] = st_q.s3[i];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign cmp.sync = st_q.o;
endmodule // ocfs_sync

// ===== src/ocfs_timer.sv
module ocfs_timer
	import ocfs_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic start, // Restart wait
	output logic done // Wait expired, one-cycle pulse
);
	typedef struct packed {
		logic [19:0] cnt;
		logic run;
		logic done;
	} ocfs_tmr_st_type;

	ocfs_tmr_st_type st_q, st_d;

	always_comb begin
		st_d = st_q;
		if (ce) begin
			st_d.done = 1'b0;
			if (start) begin
				st_d.cnt = WAIT_CYC - 20'h1;
				st_d.run = 1'b1;
			end else if (st_q.run) begin
				if (st_q.cnt == 20'h0) begin
					st_d.run = 1'b0;
					st_d.done = 1'b1;
				end else begin
					st_d.cnt = st_q.cnt - 20'h1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign done = st_q.done;
endmodule // ocfs_timer

// ===== tb/ocfs_top_monitor.sv
module ocfs_top_monitor
	import ocfs_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic cmp_high, // High level
	input wire logic cmp_nom, // Nominal level
	input wire logic cmp_aux, // Aux trip
	input wire logic [1:0] channel_current_limit, // Limits
	input wire logic [1:0] upper_gate_drive, // Upper gates
	input wire logic [1:0] lower_gate_drive, // Lower gates
	input wire logic aux_upper_gate, // Aux upper
	input wire logic aux_lower_gate, // Aux lower
	input wire logic [3:0] ext_pwm_oe, // Ext enables
	input wire logic power_good_oe, // Power-good pull
	input wire logic overcurrent_timer_source, // Charge
	input wire logic overcurrent_timer_ground, // Ground
	input wire logic ss_start // Soft-start pulse
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_shut_all_off:
		assert property ($rose(power_good_oe) && cmp_high |-> upper_gate_drive == 2'h0
			&& lower_gate_drive == 2'h0 && ext_pwm_oe == 4'h0) else $error("gates on at shutdown");
	chk_high_trip:
		assert property (cmp_high [*8] |-> upper_gate_drive == 2'h0 && lower_gate_drive == 2'h0
			&& power_good_oe) else $error("no trip on high current");
	chk_limit_upper:
		assert property (channel_current_limit[0] [*8] |-> !upper_gate_drive[0])
			else $error("upper gate on while limited");
	chk_limit_lower:
		assert property (channel_current_limit[0] [*8] && !power_good_oe |-> lower_gate_drive[0])
			else $error("lower gate off while limited");
	chk_timer_excl:
		assert property (overcurrent_timer_source |-> !overcurrent_timer_ground)
			else $error("timer pin charged and grounded");
	chk_timer_ground:
		assert property (!cmp_nom [*8] |-> overcurrent_timer_ground)
			else $error("timer pin not grounded");
	chk_aux_only:
		assert property (cmp_aux [*8] |-> !aux_upper_gate && !aux_lower_gate)
			else $error("aux gates on during aux fault");
	chk_ss_pulse:
		assert property (ss_start |=> !ss_start) else $error("soft-start request too long");
endmodule // ocfs_top_monitor

bind ocfs_top ocfs_top_monitor ocfs_top_monitor_inst (.*);

// ===== tb/ocfs_stage_model.sv
module ocfs_stage_model #(
	parameter int SS_CYC = 200
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset
	input wire logic ss_start, // Soft-start request
	output wire logic ss_done, // Soft-start finished
	output logic [1:0] pwm_core, // Core PWM
	output logic pwm_aux, // Aux PWM
	output logic [3:0] pwm_ext // Ext PWM
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] cnt_q;
	logic [3:0] ph_q;
	logic done_q;
	// A new request hides the stale finish flag at once, so a retry is not seen as complete
	assign ss_done = done_q & ~ss_start;
	// Idle code 0xff keeps the ramp from finishing before anyone asked for it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'hff;
			done_q <= 1'b0;
			ph_q <= 4'h0;
		end else begin
			ph_q <= ph_q + 4'h1;
			if (ss_start) begin
				cnt_q <= 8'h00;
				done_q <= 1'b0;
			end else if (cnt_q == 8'(SS_CYC)) begin
				done_q <= 1'b1;
				cnt_q <= 8'hff;
			end else if (cnt_q != 8'hff) begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
	assign pwm_core = {ph_q[2], ~ph_q[2]};
	assign pwm_aux = ph_q[3];
	assign pwm_ext = {ph_q[1:0], ph_q[1:0]};
endmodule // ocfs_stage_model

// ===== tb/ocfs_top_tb.sv
module ocfs_top_tb
	import ocfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ss_done, pwm_aux, ss_start;
	logic cmp_nom, cmp_high, cmp_aux, aux_upper_gate, aux_lower_gate, power_good_o, power_good_oe;
	logic cmp_raised;
	logic overcurrent_timer_source, overcurrent_timer_ground, power_saving_request_bit;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] pwm_core, channel_current_limit, upper_gate_drive, lower_gate_drive;
	logic [3:0] pwm_ext, ext_pwm_o, ext_pwm_oe;
	logic err;
	int bad_count, compares, n;
	ocfs_top ocfs_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ss_done(ss_done), .pwm_core(pwm_core),
		.pwm_aux(pwm_aux), .pwm_ext(pwm_ext), .ext_active(4'h3), .cmp_nom(cmp_nom),
		.cmp_raised(cmp_raised), .cmp_high(cmp_high), .cmp_psm(1'b0), .cmp_cap(1'b0),
		.cmp_aux(cmp_aux), .channel_current_limit(channel_current_limit),
		.upper_gate_drive(upper_gate_drive), .lower_gate_drive(lower_gate_drive),
		.aux_upper_gate(aux_upper_gate), .aux_lower_gate(aux_lower_gate), .ext_pwm_o(ext_pwm_o),
		.ext_pwm_oe(ext_pwm_oe), .power_good_o(power_good_o), .power_good_oe(power_good_oe),
		.overcurrent_timer_source(overcurrent_timer_source),
		.overcurrent_timer_ground(overcurrent_timer_ground), .ss_start(ss_start),
		.power_saving_request_bit(power_saving_request_bit));
	ocfs_stage_model ocfs_stage_model_inst (.pclk(pclk), .presetn(presetn), .ss_start(ss_start),
		.ss_done(ss_done), .pwm_core(pwm_core), .pwm_aux(pwm_aux), .pwm_ext(pwm_ext));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task summarize;
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wt(input int c);
		repeat (c) @(posedge pclk);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{cmp_nom, cmp_high, cmp_aux, cmp_raised, channel_current_limit} = '0;
		wt(20);
		presetn <= 1'b1;
		wt(2);
		chk("reset pins", {power_good_oe, overcurrent_timer_ground, upper_gate_drive}, 4'hc);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl reset", rd, 32'h0);
		// Unmapped word must be refused
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped err", err, 1'b1);
		cmp_nom <= 1'b1;
		apb(1'b1, ADDR_CTRL, 32'h1);
		wt(20);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("soft state", rd[2:0], 3'h1);
		chk("timer idle soft", overcurrent_timer_ground, 1'b1);
		n = 0;
		while (ss_done !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		wt(10);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("run state", rd[2:0], 3'h2);
		chk("timer charge", overcurrent_timer_source, 1'b1);
		cmp_nom <= 1'b0;
		wt(10);
		chk("timer ground", overcurrent_timer_ground, 1'b1);
		channel_current_limit <= 2'h1;
		wt(10);
		chk("limit gates", {upper_gate_drive[0], lower_gate_drive[0]}, 2'h1);
		wt(20);
		chk("limit hold", upper_gate_drive[0], 1'b0);
		channel_current_limit <= 2'h0;
		cmp_aux <= 1'b1;
		wt(10);
		chk("aux off", {aux_upper_gate, aux_lower_gate}, 2'h0);
		chk("core on", |{upper_gate_drive, lower_gate_drive}, 1'b1);
		cmp_aux <= 1'b0;
		cmp_high <= 1'b1;
		wt(10);
		chk("shutdown", {upper_gate_drive, lower_gate_drive, ext_pwm_oe, power_good_oe}, 9'h1);
		cmp_high <= 1'b0;
		n = 0;
		while (ss_start !== 1'b1 && n < WAIT_CYC_INT + 100) begin
			@(posedge pclk);
			n++;
		end
		chk("wait span", n >= WAIT_CYC_INT - 30 && n <= WAIT_CYC_INT + 5, 1'b1);
		chk("retry", ss_start, 1'b1);
		cmp_raised <= 1'b1;
		wt(10);
		cmp_raised <= 1'b0;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("raised trip", rd[2:0], 3'h3);
		apb(1'b0, ADDR_COUNT, 32'h0);
		chk("core tries", rd[2:0], 3'h2);
		summarize;
	end
	initial begin
		wt(WAIT_CYC_INT + 20000);
		bad_count++;
		summarize;
	end
endmodule // ocfs_top_tb
